// >>> include/dopc_pkg.sv
// Purpose: Shared constants for the pulse output channel.
// Assumes: 200 MHz mclk, 32-bit classic Wishbone register access.
// Notes:   Offsets are byte addresses of aligned words.
`default_nettype none
package dopc_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int TICK_PERIOD_NS  = 100_000_000;               // 100 ms unit
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_INACT = 8'h0C;
  localparam logic [7:0] OFS_ACT   = 8'h10;
  localparam logic [7:0] OFS_DELAY = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  // ==========================================================
  // Control, command and status field positions
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_TYPE_LO  = 1;
  localparam int CTL_HAND_LO  = 3;
  localparam int CTL_PMODE    = 5;
  localparam int CTL_FAIL_LO  = 6;
  localparam int CTL_RELAY    = 8;
  localparam int CMD_ACT      = 0;
  localparam int CMD_DEACT    = 1;
  localparam int STAT_STATE_LO = 8;
  localparam int STAT_LEFT_LO  = 16;
  // ==========================================================
  // Encodings
  localparam logic [1:0] TYPE_SINK   = 2'h0;
  localparam logic [1:0] TYPE_SOURCE = 2'h1;
  localparam logic [1:0] TYPE_BOTH   = 2'h2;
  localparam logic [1:0] HAND_MANUAL = 2'h0;
  localparam logic [1:0] HAND_PULSE  = 2'h1;
  localparam logic [1:0] HAND_I2A    = 2'h2;
  localparam logic [1:0] HAND_A2I    = 2'h3;
  localparam logic [1:0] FAIL_NONE   = 2'h0;
  localparam logic [1:0] FAIL_ACT    = 2'h1;
  localparam logic [1:0] FAIL_DEACT  = 2'h2;
  // ==========================================================
  // Reset values
  localparam logic [8:0]  CTRL_RST  = 9'h000;  // Disabled, sink, manual, continuous
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [13:0] WIDTH_RST = 14'h0001;
  // ==========================================================
  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_PREON  = 6'b00_0010,
    ST_TIMED  = 6'b00_0100,
    ST_PACT   = 6'b00_1000,
    ST_PINACT = 6'b01_0000,
    ST_DWAIT  = 6'b10_0000
  } dopc_state_t;
endpackage : dopc_pkg
`default_nettype wire

// >>> rtl/dopc_tick.sv
// Purpose: Timebase that pulses once per unit period.
// Assumes: Restart realigns the period to the restart cycle.
// Notes:   Tick output is registered, one cycle wide.
`default_nettype none
module dopc_tick #(
  parameter int TICK_CYCLES = dopc_pkg::TICK_CYCLES_DEF
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic restart,
  output logic      tick
);
  import dopc_pkg::*;
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  // ==========================================================
  // Divider
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (restart) begin
      next_cnt = '0;
    end else if (cnt == LAST) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : dopc_tick
`default_nettype wire

// >>> rtl/dopc_channel.sv
// Purpose: One digital output / relay channel with manual, pulse,
//          delay and failsafe handling, registers on Wishbone.
// Assumes: failsafe_fire is a one-cycle pulse from an outside timer.
// Notes:   Widths and delays count whole 100 ms ticks.
//
// Overview of operation
// - Sink type grounds line when active only
// - Source type drives supply when active only
// - Sink-and-source grounds inactive, drives active
// - Line driven only when output enabled
// - Manual mode follows activate/deactivate commands
// - Pulse mode alternates phases after activate
// - Inactive-to-active: hold inactive, then activate
// - Active-to-inactive: activate, then drop after delay
// - Continuous pulse repeats until commanded otherwise
// - Counted pulse makes exactly configured cycles, one for a zero count
// - Inactive phase lasts configured width
// - Active phase lasts configured width
// - Deactivate executes after configured delay
// - Failsafe fire applies configured action
// - Action none leaves output unchanged
// - Action forces output active or inactive
// - Relay mode switches, no type selection
`default_nettype none
module dopc_channel
  import dopc_pkg::*;
#(
  parameter int TICK_CYCLES = dopc_pkg::TICK_CYCLES_DEF,
  parameter int WIDTH_W     = 14,
  parameter int COUNT_W     = 16
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        failsafe_fire,
  output logic             line_out,
  output logic             line_oe,
  output logic             relay_on
);
  import dopc_pkg::*;

  // ==========================================================
  // Register file
  logic [8:0]         ctrl;
  logic [COUNT_W-1:0] count_cfg;
  logic [WIDTH_W-1:0] inact_w;
  logic [WIDTH_W-1:0] act_w;
  logic [WIDTH_W-1:0] delay_w;
  logic [8:0]         next_ctrl;
  logic [COUNT_W-1:0] next_count_cfg;
  logic [WIDTH_W-1:0] next_inact_w;
  logic [WIDTH_W-1:0] next_act_w;
  logic [WIDTH_W-1:0] next_delay_w;
  logic [31:0]        next_dat_o;
  logic               next_ack;
  logic               wr_en;
  logic               cmd_act;
  logic               cmd_deact;
  logic [31:0]        wmask;
  logic [31:0]        rd_data;

  // Sequencer
  dopc_state_t        state;
  dopc_state_t        next_state;
  logic [WIDTH_W-1:0] timer;
  logic [WIDTH_W-1:0] next_timer;
  logic [COUNT_W-1:0] left;
  logic [COUNT_W-1:0] next_left;
  logic               active;
  logic               next_active;
  logic               tick;
  logic               restart;
  logic               expire;
  logic               next_line_out;
  logic               next_line_oe;
  logic               next_relay_on;

  wire logic       enable = ctrl[CTL_ENABLE];
  wire logic [1:0] otype  = ctrl[CTL_TYPE_LO +: 2];
  wire logic [1:0] hand   = ctrl[CTL_HAND_LO +: 2];
  wire logic       counted = ctrl[CTL_PMODE];
  wire logic [1:0] fail   = ctrl[CTL_FAIL_LO +: 2];
  wire logic       relay  = ctrl[CTL_RELAY];

  // A zero width would wrap and expire only after 16384 ticks, so it is served as one unit
  function automatic logic [WIDTH_W-1:0] min1(input logic [WIDTH_W-1:0] v);
    min1 = (v == '0) ? WIDTH_W'(1) : v;
  endfunction : min1

  // ==========================================================
  // Wishbone slave: one wait state, ack drops after one cycle
  always_comb begin
    wr_en     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    next_ack  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    cmd_act   = wr_en && (wb_adr_i == OFS_CMD) && wb_sel_i[0] && wb_dat_i[CMD_ACT];
    cmd_deact = wr_en && (wb_adr_i == OFS_CMD) && wb_sel_i[0] && wb_dat_i[CMD_DEACT];
    next_ctrl      = ctrl;
    next_count_cfg = count_cfg;
    next_inact_w   = inact_w;
    next_act_w     = act_w;
    next_delay_w   = delay_w;
    if (wr_en) begin
      case (wb_adr_i)
        OFS_CTRL:  next_ctrl = 9'((ctrl & ~wmask[8:0]) | (wb_dat_i[8:0] & wmask[8:0]));
        OFS_COUNT: next_count_cfg = COUNT_W'((count_cfg & ~wmask[COUNT_W-1:0])
                                    | (wb_dat_i[COUNT_W-1:0] & wmask[COUNT_W-1:0]));
        OFS_INACT: next_inact_w = WIDTH_W'((inact_w & ~wmask[WIDTH_W-1:0])
                                  | (wb_dat_i[WIDTH_W-1:0] & wmask[WIDTH_W-1:0]));
        OFS_ACT:   next_act_w = WIDTH_W'((act_w & ~wmask[WIDTH_W-1:0])
                                | (wb_dat_i[WIDTH_W-1:0] & wmask[WIDTH_W-1:0]));
        OFS_DELAY: next_delay_w = WIDTH_W'((delay_w & ~wmask[WIDTH_W-1:0])
                                  | (wb_dat_i[WIDTH_W-1:0] & wmask[WIDTH_W-1:0]));
        default: ;
      endcase
    end
    // Read mux; unmapped and command offsets read as zero
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      OFS_CTRL:  rd_data[8:0] = ctrl;
      OFS_COUNT: rd_data[COUNT_W-1:0] = count_cfg;
      OFS_INACT: rd_data[WIDTH_W-1:0] = inact_w;
      OFS_ACT:   rd_data[WIDTH_W-1:0] = act_w;
      OFS_DELAY: rd_data[WIDTH_W-1:0] = delay_w;
      OFS_STAT: begin
        rd_data[0] = active;
        rd_data[STAT_STATE_LO +: 6] = state;
        rd_data[STAT_LEFT_LO +: COUNT_W] = left;
      end
      default: ;
    endcase
    next_dat_o = (next_ack && !wb_we_i) ? rd_data : 32'h0000_0000;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl      <= CTRL_RST;
      count_cfg <= COUNT_RST;
      inact_w   <= WIDTH_RST;
      act_w     <= WIDTH_RST;
      delay_w   <= WIDTH_RST;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
    end else if (ce) begin
      ctrl      <= next_ctrl;
      count_cfg <= next_count_cfg;
      inact_w   <= next_inact_w;
      act_w     <= next_act_w;
      delay_w   <= next_delay_w;
      wb_ack_o  <= next_ack;
      wb_dat_o  <= next_dat_o;
    end
  end

  // ==========================================================
  // Timebase, realigned by each command so phases start exact
  assign restart = cmd_act || cmd_deact;

  dopc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk   (mclk),
    .reset  (reset),
    .ce     (ce),
    .restart(restart),
    .tick   (tick)
  );

  // ==========================================================
  // Sequencer: failsafe outranks a command in the same cycle
  always_comb begin
    next_state  = state;
    next_timer  = timer;
    next_left   = left;
    next_active = active;
    expire      = tick && (timer == WIDTH_W'(1));
    if (failsafe_fire && fail != FAIL_NONE) begin
      next_state  = ST_IDLE;
      next_active = (fail == FAIL_ACT);
    end else if (cmd_deact) begin
      next_state = ST_DWAIT;
      next_timer = min1(delay_w);
    end else if (cmd_act) begin
      case (hand)
        HAND_MANUAL: begin
          next_state  = ST_IDLE;
          next_active = 1'b1;
        end
        HAND_PULSE: begin
          next_state  = ST_PACT;
          next_active = 1'b1;
          next_timer  = min1(act_w);
          next_left   = (count_cfg == '0) ? COUNT_W'(1) : count_cfg;
        end
        HAND_I2A: begin
          next_state  = ST_PREON;
          next_active = 1'b0;
          next_timer  = min1(delay_w);
        end
        default: begin
          next_state  = ST_TIMED;
          next_active = 1'b1;
          next_timer  = min1(delay_w);
        end
      endcase
    end else if (tick) begin
      next_timer = timer - WIDTH_W'(1);
      case (state)
        ST_PREON: if (expire) begin
          next_state  = ST_IDLE;
          next_active = 1'b1;
        end
        ST_TIMED: if (expire) begin
          next_state  = ST_IDLE;
          next_active = 1'b0;
        end
        ST_PACT: if (expire) begin
          next_state  = ST_PINACT;
          next_active = 1'b0;
          next_timer  = min1(inact_w);
        end
        ST_PINACT: if (expire) begin
          if (counted && left == COUNT_W'(1)) begin
            next_state = ST_IDLE;
            next_left  = '0;
          end else begin
            next_state  = ST_PACT;
            next_active = 1'b1;
            next_timer  = min1(act_w);
            if (counted) begin
              next_left = left - COUNT_W'(1);
            end
          end
        end
        ST_DWAIT: if (expire) begin
          next_state  = ST_IDLE;
          next_active = 1'b0;
        end
        default: begin
          next_timer = timer;
        end
      endcase
    end
  end

  // ==========================================================
  // Pin drive from the next level, so pins track state exactly
  always_comb begin
    next_relay_on = relay && enable && next_active;
    next_line_out = 1'b0;
    next_line_oe  = 1'b0;
    if (enable && !relay) begin
      case (otype)
        TYPE_SOURCE: begin
          next_line_out = 1'b1;
          next_line_oe  = next_active;
        end
        TYPE_BOTH: begin
          next_line_out = next_active;
          next_line_oe  = 1'b1;
        end
        default: begin
          next_line_out = 1'b0;
          next_line_oe  = next_active;
        end
      endcase
    end
  end

  // Sequencer and pin registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state    <= ST_IDLE;
      timer    <= '0;
      left     <= '0;
      active   <= 1'b0;
      line_out <= 1'b0;
      line_oe  <= 1'b0;
      relay_on <= 1'b0;
    end else if (ce) begin
      state    <= next_state;
      timer    <= next_timer;
      left     <= next_left;
      active   <= next_active;
      line_out <= next_line_out;
      line_oe  <= next_line_oe;
      relay_on <= next_relay_on;
    end
  end
endmodule : dopc_channel
`default_nettype wire

// >>> bench/dopc_channel_asserts.sv
// Purpose: Port-level checks for the pulse output channel.
// Assumes: Control is written through byte lanes 0 and 1.
// Notes:   Control is shadowed from bus writes seen at the ports.
`default_nettype none
module dopc_channel_asserts
  import dopc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        failsafe_fire,
  input wire logic        line_out,
  input wire logic        line_oe,
  input wire logic        relay_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sh, sh_d, next_sh;
  logic       take, act, steady, dig;
  // ==========================================================
  // Control shadow; the delayed copy marks a settled setup
  assign take = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_comb begin
    next_sh = sh;
    if (take && wb_we_i && wb_adr_i == OFS_CTRL) begin
      if (wb_sel_i[0]) next_sh[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_sh[8] = wb_dat_i[8];
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sh   <= CTRL_RST;
      sh_d <= CTRL_RST;
    end else begin
      sh   <= next_sh;
      sh_d <= sh;
    end
  end
  // Active as the load sees it, per mode and type
  assign act = sh[CTL_RELAY] ? relay_on
             : (sh[2:1] == TYPE_SINK) ? line_oe : (line_oe && line_out);
  assign steady = (sh == sh_d) && sh[CTL_ENABLE];
  assign dig = steady && !sh[CTL_RELAY];
  // ==========================================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_fire(logic [1:0] code);
    ce && failsafe_fire && steady && sh[7:6] == code;
  endsequence
  a_ack_follows: assert property (take |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_off_undriven: assert property (
    !sh[0] && !sh_d[0] |-> !line_oe && !relay_on) else $error("driven while off");
  a_relay_no_line: assert property (
    sh[8] && sh_d[8] |-> !line_oe) else $error("line driven in relay mode");
  a_sink_grounds: assert property (
    dig && sh[2:1] == TYPE_SINK && line_oe |-> !line_out) else $error("sink drove high");
  a_source_high: assert property (
    dig && sh[2:1] == TYPE_SOURCE && line_oe |-> line_out) else $error("source drove low");
  a_both_driven: assert property (
    dig && sh[2:1] == TYPE_BOTH |-> line_oe) else $error("both type undriven");
  a_fail_force: assert property (
    s_fire(FAIL_ACT) |=> act) else $error("failsafe did not activate");
  a_fail_clear: assert property (
    s_fire(FAIL_DEACT) |=> !act) else $error("failsafe did not deactivate");
endmodule : dopc_channel_asserts
`default_nettype wire

// >>> bench/dopc_load.sv
// Purpose: Load on the channel line: lamp, coil or strobe.
// Assumes: A released line has no pull and wanders.
// Notes:   Energized follows current flow for the chosen type.
`default_nettype none
module dopc_load
  import dopc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       line_out,
  input  wire logic       line_oe,
  input  wire logic       relay_on,
  input  wire logic       relay_mode,
  input  wire logic [1:0] out_type,
  output logic            wire_lvl,
  output logic            energized
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flt = 1'b0;
  // Undriven line toggles so a stale level never passes for a drive
  always @(posedge mclk) flt <= ~flt;
  assign wire_lvl = line_oe ? line_out : flt;
  assign energized = relay_mode ? relay_on
                   : (out_type == TYPE_SINK) ? (line_oe && !wire_lvl)
                   : (line_oe && wire_lvl);
endmodule : dopc_load
`default_nettype wire

// >>> bench/tb_dopc_channel.sv
// Purpose: Self-checking bench for the pulse output channel.
// Assumes: Short tick of 10 cycles stands for the 100 ms unit.
// Notes:   Seeded xorshift picks widths, counts and output types.
`default_nettype none
module tb_dopc_channel;
  timeunit 1ns;
  timeprecision 1ps;
  import dopc_pkg::*;
  localparam int T = 10;
  // Offsets read back after reset, each with the word it must hold
  localparam logic [7:0]  RST_OFS [7] = '{OFS_CTRL, OFS_COUNT, OFS_INACT, OFS_ACT, OFS_DELAY,
                                          OFS_CMD, 8'h1c};
  localparam logic [31:0] RST_VAL [7] = '{32'(CTRL_RST), 32'(COUNT_RST), 32'(WIDTH_RST),
                                          32'(WIDTH_RST), 32'(WIDTH_RST), 32'h0000_0000,
                                          32'h0000_0000};
  logic        mclk = 1'b0, reset = 1'b1, ce = 1'b1, failsafe_fire = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, seed = 32'h0000_91dc, q;
  logic        wb_ack_o, line_out, line_oe, relay_on, md = 1'b0, energized;
  logic [1:0]  ty = 2'h0;
  int          fails = 0, cmp_count = 0, ncyc = 0, a, i, d, c;
  dopc_channel #(.TICK_CYCLES(T)) dut_u (.mclk, .reset, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .failsafe_fire,
    .line_out, .line_oe, .relay_on);
  dopc_load load_u (.mclk, .line_out, .line_oe, .relay_on, .relay_mode(md),
    .out_type(ty), .wire_lvl(), .energized);
  // ==========================================================
  // Clock, watchdog and helpers
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    ncyc++;
    if (ncyc == 8000) begin
      fails++;
      complete_run();
    end
  end
  function automatic int rnd(int m);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return 1 + seed % m;
  endfunction : rnd
  // Expected activity k cycles after the command edge
  function automatic logic exp_act(int k, int em, int a, int i, int d, int c);
    case (em)
      0: return 1'b1;
      2: return k >= d * T + 1;
      3: return k < d * T + 1;
      default: ;
    endcase
    if (k < a * T + 1) return 1'b1;
    k -= a * T + 1;
    for (int p = 1; 1; p++) begin
      if (k < i * T) return 1'b0;
      k -= i * T;
      if (c != 0 && p >= c) return 1'b0;
      if (k < a * T) return 1'b1;
      k -= a * T;
    end
  endfunction : exp_act
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // Classic single cycle; released only after ack is sampled
  task automatic wb(logic w, logic [7:0] adr, logic [31:0] dat);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic run(string nm, logic [8:0] ctl, logic [1:0] cmd, int em, int len);
    wb(1'b1, OFS_ACT, a);
    wb(1'b1, OFS_INACT, i);
    wb(1'b1, OFS_DELAY, d);
    wb(1'b1, OFS_COUNT, c);
    wb(1'b1, OFS_CTRL, {23'h0, ctl});
    md = ctl[CTL_RELAY];
    ty = ctl[2:1];
    wb(1'b1, OFS_CMD, {30'h0, cmd});
    for (int k = 1; k <= len; k++) begin
      #1 chk(nm, exp_act(k, em, a, i, d, ctl[CTL_PMODE] ? c : 0), energized);
      @(posedge mclk);
    end
    $display("test %s done", nm);
  endtask : run
  task automatic fs(logic [1:0] fa, logic ex);
    wb(1'b1, OFS_CTRL, {23'h0, 1'b0, fa, 1'b0, HAND_MANUAL, TYPE_SINK, 1'b1});
    @(posedge mclk);
    failsafe_fire <= 1'b1;
    @(posedge mclk);
    failsafe_fire <= 1'b0;
    #1 chk("failsafe", ex, energized);
  endtask : fs
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    for (int n = 0; n < 7; n++) begin
      wb(1'b0, RST_OFS[n], 32'h0000_0000);
      chk("reset value", RST_VAL[n], q);
    end
    $display("test reset values done");
    for (int n = 0; n < 4; n++) begin
      a = rnd(3);
      i = rnd(3);
      c = rnd(3);
      d = 1;
      run("counted", {3'b000, 1'b1, HAND_PULSE, 2'(rnd(3) - 1), 1'b1}, 2'b01, 1,
          c * (a + i) * T + T);
      wb(1'b0, OFS_STAT, 32'h0000_0000);
      chk("idle status", 32'h0000_0100, q & 32'h0000_ff01);
      wb(1'b0, OFS_ACT, 32'h0000_0000);
      chk("act width", 32'(a), q);
    end
    a = rnd(3);
    i = rnd(3);
    run("relay pulse", {3'b100, 1'b0, HAND_PULSE, 2'b00, 1'b1}, 2'b01, 1,
        3 * (a + i) * T);
    d = rnd(4);
    run("delay on", {3'b000, 1'b0, HAND_I2A, TYPE_SOURCE, 1'b1}, 2'b01, 2, d * T + 8);
    d = rnd(4);
    run("delay off", {3'b000, 1'b0, HAND_A2I, TYPE_BOTH, 1'b1}, 2'b01, 3, d * T + 8);
    run("manual on", {3'b000, 1'b0, HAND_MANUAL, TYPE_SINK, 1'b1}, 2'b01, 0, 5);
    d = rnd(4);
    run("manual off", {3'b000, 1'b0, HAND_MANUAL, TYPE_SINK, 1'b1}, 2'b10, 3, d * T + 8);
    fs(FAIL_ACT, 1'b1);
    fs(FAIL_NONE, 1'b1);
    fs(FAIL_DEACT, 1'b0);
    fs(FAIL_NONE, 1'b0);
    $display("test failsafe done");
    complete_run();
  end
endmodule : tb_dopc_channel
bind dopc_channel dopc_channel_asserts chk_u (.mclk, .reset, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .failsafe_fire,
  .line_out, .line_oe, .relay_on);
`default_nettype wire
